/* logic/ccr_register_bank.sv */
// Serial slave and the first three control registers of a battery charger.
// Assumes bus lines, pins and event pulses are synchronous to clk_i.
//
// Contract
// - High-impedance bit, cleared by both resets
// - Input limit five bits, register reset only
// - Source detection overwrites limit; pin high 500mA
// - Later host writes to limit are kept
// - Watchdog kick bit restarts timer, self-clears
// - Charge needs pin low and enable bit
// - System minimum code, reset 101, register reset
// - Low resistance when bit set or limit>=700mA
// - Charge current resets to 100010 on both
// - Zero charge current disables charging
// - Charge current above 110010 is clamped
// - Slave at address 6AH, standard/fast speeds
// - Reads above 0x0B return 0xFF
// - Multi-byte transfers auto-increment register address
`timescale 1ns/1ps
module ccr_register_bank #(
	parameter logic [4:0] ILIM_SOURCE_LOW_CODE = 5'h17  // Limit when source pin is low
) (
	input  wire logic       clk_i,                // System clock, 25 MHz
	input  wire logic       reset_i,              // Asynchronous reset, active high
	input  wire logic       scl_i,                // Serial clock pin level
	input  wire logic       sda_i,                // Serial data pin level
	output logic            sda_o,                // Serial data drive value
	output logic            sda_oe_o,             // High while pulling data low
	input  wire logic       register_reset_i,     // Software register reset pulse
	input  wire logic       watchdog_expired_i,   // Watchdog expiry pulse
	input  wire logic       detection_done_i,     // Source detection finished pulse
	input  wire logic       source_select_i,      // Source-select pin level
	input  wire logic       charge_enable_n_i,    // Charge-enable pin, active low
	output logic            input_high_impedance_enable_o,
	output logic [4:0]      input_current_limit_o,
	output logic            light_load_modulation_disable_o,
	output logic            watchdog_kick_o,      // One-cycle timer restart
	output logic            charge_allowed_o,     // Charging permitted
	output logic [2:0]      system_minimum_voltage_o,
	output logic            input_fet_low_resistance_select_o,
	output logic [5:0]      fast_charge_current_o
);
	import ccr_pkg::*;
	typedef struct packed {
		ccr_state_t st;       // Serial slave state
		logic [3:0] cnt;      // Bits of the current byte
		logic [7:0] sh;       // Shift register
		logic [7:0] ptr;      // Register pointer
		logic       rw;       // Transfer is a read
		logic       sda_low;  // Pull data line low
		logic       mack;     // Master acked last read byte
		logic       hiz;      // input_high_impedance_enable
		logic [4:0] ilim;     // input_current_limit
		logic       pfm;      // light_load_modulation_disable
		logic       kick;     // watchdog_kick
		logic       chg;      // charge_enable_bit
		logic [2:0] sysmin;   // system_minimum_voltage
		logic       fet;      // input_fet_low_resistance_select bit
		logic [5:0] fast_charge_current;     // fast_charge_current
		logic       allowed;  // Registered charge permission
		logic       lowres;   // Registered resistance choice
	} ccr_bank_state_t;

	ccr_bank_state_t q_ff;    // All state
	ccr_bank_state_t nxt_q;   // Next state
	logic            ev_start;  // Start condition
	logic            ev_stop;   // Stop condition
	logic            ev_rise;   // Serial clock rising
	logic            ev_fall;   // Serial clock falling
	logic [7:0]      load_byte; // Register at the pointer; a call result cannot be sliced

	////////////////////////////////////////////////////////////////////////////
	// Line condition detector
	ccr_line_monitor u_line (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.scl_i   (scl_i),
		.sda_i   (sda_i),
		.start_o (ev_start),
		.stop_o  (ev_stop),
		.rise_o  (ev_rise),
		.fall_o  (ev_fall)
	);

	////////////////////////////////////////////////////////////////////////////
	// Read value of a register; used at each byte load
	function automatic logic [7:0] reg_read(input logic [7:0] adr, input ccr_bank_state_t s);
		logic [7:0] v;
		v = 8'h00;
		case (adr)
			ADR_INPUT_SOURCE: begin
				v[HIZ_BIT]        = s.hiz;
				v[ILIM_MSB:0]     = s.ilim;
			end
			ADR_SYSTEM_CONFIG: begin
				v[PFM_BIT]                = s.pfm;
				v[KICK_BIT]               = s.kick;
				v[CHG_BIT]                = s.chg;
				v[SYSMIN_MSB:SYSMIN_LSB]  = s.sysmin;
			end
			ADR_FAST_CHARGE: begin
				v[FET_BIT]        = s.fet;
				v[FAST_CHARGE_CURRENT_MSB:0]     = s.fast_charge_current;
			end
			default: begin
				v = (adr > ADR_LAST_DEFINED) ? READ_BEYOND_MAP : READ_OUTSIDE_BANK;
			end
		endcase
		return v;
	endfunction
	assign load_byte = reg_read(q_ff.ptr, q_ff);

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic: slave, register writes, resets, derived outputs
	always_comb begin
		nxt_q = q_ff;
		nxt_q.kick = 1'b0;
		if (detection_done_i) begin
			nxt_q.ilim = source_select_i ? ILIM_500MA : ILIM_SOURCE_LOW_CODE;
		end
		if (ev_start) begin
			// A repeated start restarts address phase at any point
			nxt_q.st      = ST_ADDR;
			nxt_q.cnt     = 4'h0;
			nxt_q.sda_low = 1'b0;
		end else if (ev_stop) begin
			nxt_q.st      = ST_IDLE;
			nxt_q.sda_low = 1'b0;
		end else if (ev_rise) begin
			case (q_ff.st)
				ST_ADDR, ST_REGADR, ST_WDATA: begin
					// Sample data while clock is high
					nxt_q.sh  = {q_ff.sh[6:0], sda_i};
					nxt_q.cnt = 4'(q_ff.cnt + 4'h1);
				end
				ST_RDATA_ACK: begin
					nxt_q.mack = ~sda_i;
				end
				default: begin
				end
			endcase
		end else if (ev_fall) begin
			case (q_ff.st)
				ST_ADDR: begin
					if (q_ff.cnt == BITS_PER_BYTE) begin
						if (q_ff.sh[7:1] == SLAVE_ADDR) begin
							nxt_q.st      = ST_ADDR_ACK;
							nxt_q.rw      = q_ff.sh[0];
							nxt_q.sda_low = 1'b1;
						end else begin
							nxt_q.st = ST_IDLE;
						end
					end
				end
				ST_REGADR: begin
					if (q_ff.cnt == BITS_PER_BYTE) begin
						// Undefined register address is refused
						if (q_ff.sh <= ADR_LAST_DEFINED) begin
							nxt_q.st      = ST_REGADR_ACK;
							nxt_q.ptr     = q_ff.sh;
							nxt_q.sda_low = 1'b1;
						end else begin
							nxt_q.st = ST_IDLE;
						end
					end
				end
				ST_WDATA: begin
					if (q_ff.cnt == BITS_PER_BYTE) begin
						nxt_q.st      = ST_WDATA_ACK;
						nxt_q.sda_low = 1'b1;
						nxt_q.ptr     = 8'(q_ff.ptr + 8'h01);
						case (q_ff.ptr)
							ADR_INPUT_SOURCE: begin
								nxt_q.hiz  = q_ff.sh[HIZ_BIT];
								nxt_q.ilim = q_ff.sh[ILIM_MSB:0];
							end
							ADR_SYSTEM_CONFIG: begin
								nxt_q.pfm    = q_ff.sh[PFM_BIT];
								nxt_q.kick   = q_ff.sh[KICK_BIT];
								nxt_q.chg    = q_ff.sh[CHG_BIT];
								nxt_q.sysmin = q_ff.sh[SYSMIN_MSB:SYSMIN_LSB];
							end
							ADR_FAST_CHARGE: begin
								nxt_q.fet  = q_ff.sh[FET_BIT];
								nxt_q.fast_charge_current = (q_ff.sh[FAST_CHARGE_CURRENT_MSB:0] > FAST_CHARGE_CURRENT_MAX) ?
									FAST_CHARGE_CURRENT_MAX : q_ff.sh[FAST_CHARGE_CURRENT_MSB:0];
							end
							default: begin
							end
						endcase
					end
				end
				ST_ADDR_ACK: begin
					if (q_ff.rw) begin
						// First read byte from current pointer
						nxt_q.sh      = {load_byte[6:0], 1'b0};
						nxt_q.sda_low = ~load_byte[7];
						nxt_q.cnt     = 4'h1;
						nxt_q.ptr     = 8'(q_ff.ptr + 8'h01);
						nxt_q.st      = ST_RDATA;
					end else begin
						nxt_q.sda_low = 1'b0;
						nxt_q.cnt     = 4'h0;
						nxt_q.st      = ST_REGADR;
					end
				end
				ST_REGADR_ACK, ST_WDATA_ACK: begin
					nxt_q.sda_low = 1'b0;
					nxt_q.cnt     = 4'h0;
					nxt_q.st      = ST_WDATA;
				end
				ST_RDATA: begin
					if (q_ff.cnt == BITS_PER_BYTE) begin
						// Release for the master's acknowledge
						nxt_q.sda_low = 1'b0;
						nxt_q.st      = ST_RDATA_ACK;
					end else begin
						nxt_q.sda_low = ~q_ff.sh[7];
						nxt_q.sh      = {q_ff.sh[6:0], 1'b0};
						nxt_q.cnt     = 4'(q_ff.cnt + 4'h1);
					end
				end
				ST_RDATA_ACK: begin
					if (q_ff.mack) begin
						nxt_q.sh      = {load_byte[6:0], 1'b0};
						nxt_q.sda_low = ~load_byte[7];
						nxt_q.cnt     = 4'h1;
						nxt_q.ptr     = 8'(q_ff.ptr + 8'h01);
						nxt_q.st      = ST_RDATA;
					end else begin
						nxt_q.st = ST_IDLE;
					end
				end
				default: begin
				end
			endcase
		end
		if (watchdog_expired_i) begin
			nxt_q.hiz  = HIZ_RESET;
			nxt_q.kick = KICK_RESET;
			nxt_q.chg  = CHG_RESET;
			nxt_q.fast_charge_current = FAST_CHARGE_CURRENT_RESET;
		end
		if (register_reset_i) begin
			nxt_q.hiz    = HIZ_RESET;
			nxt_q.ilim   = ILIM_RESET;
			nxt_q.pfm    = PFM_RESET;
			nxt_q.kick   = KICK_RESET;
			nxt_q.chg    = CHG_RESET;
			nxt_q.sysmin = SYSMIN_RESET;
			nxt_q.fet    = FET_RESET;
			nxt_q.fast_charge_current   = FAST_CHARGE_CURRENT_RESET;
		end
		nxt_q.allowed = ~charge_enable_n_i & nxt_q.chg & (nxt_q.fast_charge_current != FAST_CHARGE_CURRENT_ZERO);
		nxt_q.lowres  = nxt_q.fet | (nxt_q.ilim >= ILIM_700MA);
	end

	////////////////////////////////////////////////////////////////////////////
	// State register; charge stays off until the first clock after reset
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			q_ff <= '{st: ST_IDLE, cnt: 4'h0, sh: 8'h00, ptr: 8'h00, rw: 1'b0,
				sda_low: 1'b0, mack: 1'b0, hiz: HIZ_RESET, ilim: ILIM_RESET,
				pfm: PFM_RESET, kick: KICK_RESET, chg: CHG_RESET,
				sysmin: SYSMIN_RESET, fet: FET_RESET, fast_charge_current: FAST_CHARGE_CURRENT_RESET,
				allowed: 1'b0, lowres: 1'b1};
		end else begin
			q_ff <= nxt_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from flops, except sda_o, which is tied to 0
	assign sda_o                             = 1'b0;
	assign sda_oe_o                          = q_ff.sda_low;
	assign input_high_impedance_enable_o     = q_ff.hiz;
	assign input_current_limit_o             = q_ff.ilim;
	assign light_load_modulation_disable_o   = q_ff.pfm;
	assign watchdog_kick_o                   = q_ff.kick;
	assign charge_allowed_o                  = q_ff.allowed;
	assign system_minimum_voltage_o          = q_ff.sysmin;
	assign input_fet_low_resistance_select_o = q_ff.lowres;
	assign fast_charge_current_o             = q_ff.fast_charge_current;
endmodule // ccr_register_bank

/* logic/ccr_pkg.sv */
// Constants shared by the charger control register bank and its line monitor.
// Assumes the serial bus pins arrive already synchronous to clk_i.
package ccr_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Serial slave identity and register addresses
	localparam logic [6:0] SLAVE_ADDR        = 7'h6a;  // Seven-bit bus address
	localparam logic [7:0] ADR_INPUT_SOURCE  = 8'h00;  // input_source_control
	localparam logic [7:0] ADR_SYSTEM_CONFIG = 8'h01;  // system_charge_config
	localparam logic [7:0] ADR_FAST_CHARGE   = 8'h02;  // fast_charge_current_control
	localparam logic [7:0] ADR_LAST_DEFINED  = 8'h0b;  // Highest mapped register
	localparam logic [7:0] READ_BEYOND_MAP   = 8'hff;  // Answer above the map
	localparam logic [7:0] READ_OUTSIDE_BANK = 8'h00;  // Mapped but held elsewhere

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int HIZ_BIT     = 7;  // input_source_control
	localparam int ILIM_MSB    = 4;
	localparam int PFM_BIT     = 7;  // system_charge_config
	localparam int KICK_BIT    = 6;
	localparam int CHG_BIT     = 4;
	localparam int SYSMIN_MSB  = 3;
	localparam int SYSMIN_LSB  = 1;
	localparam int FET_BIT     = 6;  // fast_charge_current_control
	localparam int FAST_CHARGE_CURRENT_MSB    = 5;

	////////////////////////////////////////////////////////////////////////////
	// Reset values and special codes
	localparam logic       HIZ_RESET    = 1'b0;
	localparam logic [4:0] ILIM_RESET   = 5'h17;  // 2400 mA
	localparam logic       PFM_RESET    = 1'b0;
	localparam logic       KICK_RESET   = 1'b0;
	localparam logic       CHG_RESET    = 1'b1;
	localparam logic [2:0] SYSMIN_RESET = 3'h5;   // 3.5 V
	localparam logic       FET_RESET    = 1'b0;
	localparam logic [5:0] FAST_CHARGE_CURRENT_RESET   = 6'h22;  // 2040 mA
	localparam logic [4:0] ILIM_500MA   = 5'h04;  // Source-select pin high
	localparam logic [4:0] ILIM_700MA   = 5'h06;  // Resistance switch point
	localparam logic [5:0] FAST_CHARGE_CURRENT_MAX     = 6'h32;  // 3000 mA clamp
	localparam logic [5:0] FAST_CHARGE_CURRENT_ZERO    = 6'h00;  // Charge off
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	////////////////////////////////////////////////////////////////////////////
	// Serial slave states
	typedef enum logic [3:0] {
		ST_IDLE      = 4'b0000,
		ST_ADDR      = 4'b0001,
		ST_ADDR_ACK  = 4'b0010,
		ST_REGADR    = 4'b0011,
		ST_REGADR_ACK= 4'b0100,
		ST_WDATA     = 4'b0101,
		ST_WDATA_ACK = 4'b0110,
		ST_RDATA     = 4'b0111,
		ST_RDATA_ACK = 4'b1000
	} ccr_state_t;

endpackage : ccr_pkg

/* logic/ccr_line_monitor.sv */
// Edge and condition detector for the two serial bus lines.
// Assumes scl_i and sda_i are already synchronous to clk_i.
`timescale 1ns/1ps
module ccr_line_monitor (
	input  wire logic clk_i,    // System clock
	input  wire logic reset_i,  // Asynchronous reset, active high
	input  wire logic scl_i,    // Serial clock level
	input  wire logic sda_i,    // Serial data level
	output logic      start_o,  // Start or repeated start seen
	output logic      stop_o,   // Stop seen
	output logic      rise_o,   // Serial clock rose
	output logic      fall_o    // Serial clock fell
);
	import ccr_pkg::*;

	typedef struct packed {
		logic scl;  // Last serial clock level
		logic sda;  // Last serial data level
	} ccr_line_state_t;

	ccr_line_state_t q_ff;      // Registered line levels
	ccr_line_state_t nxt_q;     // Next line levels

	////////////////////////////////////////////////////////////////////////////
	// Follow the lines every cycle
	always_comb begin
		nxt_q     = q_ff;
		nxt_q.scl = scl_i;
		nxt_q.sda = sda_i;
	end

	// Idle bus is high on both lines, so reset to that
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			q_ff <= '{scl: 1'b1, sda: 1'b1};
		end else begin
			q_ff <= nxt_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Data moving while the clock is high marks start or stop
	assign start_o = q_ff.scl & scl_i & q_ff.sda & ~sda_i;
	assign stop_o  = q_ff.scl & scl_i & ~q_ff.sda & sda_i;
	assign rise_o  = ~q_ff.scl & scl_i;
	assign fall_o  = q_ff.scl & ~scl_i;

endmodule // ccr_line_monitor

/* sim/ccr_chk.sv */
// Port-level assertions for the charger control register bank.
// Sees only the bank's ports; one clock, asynchronous active-high reset.
`timescale 1ns/1ps
module ccr_chk
	import ccr_pkg::*;
#(
	parameter logic [4:0] ILIM_SOURCE_LOW_CODE = 5'h17  // Limit chosen when pin is low
) (
	input wire logic       clk_i,
	input wire logic       reset_i,
	input wire logic       scl_i,
	input wire logic       sda_oe_o,
	input wire logic       register_reset_i,
	input wire logic       watchdog_expired_i,
	input wire logic       detection_done_i,
	input wire logic       source_select_i,
	input wire logic       charge_enable_n_i,
	input wire logic       input_high_impedance_enable_o,
	input wire logic [4:0] input_current_limit_o,
	input wire logic       watchdog_kick_o,
	input wire logic       charge_allowed_o,
	input wire logic [2:0] system_minimum_voltage_o,
	input wire logic       input_fet_low_resistance_select_o,
	input wire logic [5:0] fast_charge_current_o
);
	////////////////////////////////////////
	// All checks share the one clock and are muted in reset
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	// Kick is a single-cycle restart request
	sequence kick_once;
		watchdog_kick_o ##1 !watchdog_kick_o;
	endsequence

	a_kick_one_cycle: assert property ($rose(watchdog_kick_o) |-> kick_once)
		else $error("kick pulse longer than one cycle");
	a_pin_blocks_charge: assert property (charge_enable_n_i |=> !charge_allowed_o)
		else $error("charging with pin high");
	a_zero_current_off: assert property (charge_allowed_o |-> fast_charge_current_o != FAST_CHARGE_CURRENT_ZERO)
		else $error("charging at zero current");
	a_clamp_max: assert property (fast_charge_current_o <= FAST_CHARGE_CURRENT_MAX)
		else $error("charge current above clamp");
	a_watchdog_defaults: assert property (watchdog_expired_i && !register_reset_i |=>
		!input_high_impedance_enable_o && !watchdog_kick_o && fast_charge_current_o == FAST_CHARGE_CURRENT_RESET)
		else $error("watchdog expiry left fields set");
	a_reset_defaults: assert property (register_reset_i |=> input_current_limit_o == ILIM_RESET
		&& system_minimum_voltage_o == SYSMIN_RESET && fast_charge_current_o == FAST_CHARGE_CURRENT_RESET)
		else $error("register reset left fields set");
	a_detect_pin_high: assert property (detection_done_i && source_select_i &&
		!register_reset_i && !watchdog_expired_i |=> input_current_limit_o == ILIM_500MA)
		else $error("detection with pin high missed");
	a_detect_pin_low: assert property (detection_done_i && !source_select_i &&
		!register_reset_i && !watchdog_expired_i |=> input_current_limit_o == ILIM_SOURCE_LOW_CODE)
		else $error("detection with pin low missed");
	a_fet_above_limit: assert property (input_current_limit_o >= ILIM_700MA |->
		input_fet_low_resistance_select_o)
		else $error("high resistance at large limit");
	// Data may only move just after a clock fall, never while the clock is high
	a_drive_after_fall: assert property ($changed(sda_oe_o) |->
		!$past(scl_i) && $past(scl_i, 2))
		else $error("data drive changed off a clock fall");
endmodule // ccr_chk

bind ccr_register_bank ccr_chk #(.ILIM_SOURCE_LOW_CODE(ILIM_SOURCE_LOW_CODE)) ccr_chk_i (.*);

/* sim/ccr_host_model.sv */
// Host microcontroller model acting as serial bus master.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
module ccr_host_model (
	input  wire logic clk_i,    // Bench clock
	input  wire logic sda_i,    // Resolved data wire
	output logic      scl_o,    // Serial clock, idle high
	output logic      sda_oe_o  // High while pulling data low
);
	////////////////////////////////////////
	// Lines released at time zero: bus free
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end

	// Four clocks a phase keeps each level well clear of the sampler
	task automatic half();
		repeat (4) @(posedge clk_i);
	endtask

	// data moves only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		half();
		sda_oe_o <= ~b;
		half();
		scl_o <= 1'b1;
		half();
		r = sda_i;
		scl_o <= 1'b0;
	endtask

	// Nine clocks, MSB first; last bit is the acknowledge slot
	task automatic xfer(input logic [8:0] w, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			bit_io(w[i], r[i]);
		end
	endtask

	// start and repeated start: data falls with clock high
	task automatic start();
		half();
		sda_oe_o <= 1'b0;
		half();
		scl_o <= 1'b1;
		half();
		sda_oe_o <= 1'b1;
		half();
		scl_o <= 1'b0;
	endtask

	// stop: data rises with clock high, bus left free
	task automatic stop();
		half();
		sda_oe_o <= 1'b1;
		half();
		scl_o <= 1'b1;
		half();
		sda_oe_o <= 1'b0;
		half();
	endtask
endmodule // ccr_host_model

/* sim/tb_top.sv */
// Self-checking bench for the charger control register bank.
// Bus traffic comes from the host model; pins are driven here.
`timescale 1ns/1ps
module tb_top;
	import ccr_pkg::*;
	localparam logic [4:0] LOW_CODE = 5'h09;  // Limit for pin low, chosen here
	logic       clk_i = 1'b0;
	logic       reset_i = 1'b1;
	logic       scl, host_oe, dev_oe, dev_sda, sda;
	logic       regrst = 1'b0, wdog = 1'b0, det = 1'b0, psel = 1'b0, ce_n = 1'b0;
	logic       hiz, pfm, kick, chg_ok, fet;
	logic [4:0] ilim;
	logic [2:0] smin;
	logic [5:0] fast_charge_current;
	logic [7:0] q[$];
	int         fails = 0;
	int         checks_done = 0;
	int         kick_cycles = 0;

	// Pull-up resolves the open-drain data wire
	// The device's drive value is used, so a wrong level breaks every acknowledge
	assign sda = ~host_oe & (dev_oe ? dev_sda : 1'b1);
	always #20 clk_i = ~clk_i;
	// Count cycles with the watchdog restart raised
	always @(posedge clk_i) begin
		if (kick === 1'b1) begin
			kick_cycles++;
		end
	end

	ccr_host_model ccr_host_model_i (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
	ccr_register_bank #(.ILIM_SOURCE_LOW_CODE(LOW_CODE)) ccr_register_bank_i (
		.clk_i(clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda), .sda_o(dev_sda),
		.sda_oe_o(dev_oe), .register_reset_i(regrst), .watchdog_expired_i(wdog),
		.detection_done_i(det), .source_select_i(psel), .charge_enable_n_i(ce_n),
		.input_high_impedance_enable_o(hiz), .input_current_limit_o(ilim),
		.light_load_modulation_disable_o(pfm), .watchdog_kick_o(kick),
		.charge_allowed_o(chg_ok), .system_minimum_voltage_o(smin),
		.input_fet_low_resistance_select_o(fet), .fast_charge_current_o(fast_charge_current));

	////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic put(input logic [7:0] b, output logic ack);
		logic [8:0] r;
		ccr_host_model_i.xfer({b, 1'b1}, r);
		ack = ~r[0];
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
		logic ack;
		ccr_host_model_i.start();
		put({SLAVE_ADDR, 1'b0}, ack);
		check(8'(ack), 8'h01);
		put(a, ack);
		foreach (d[i]) put(d[i], ack);
		ccr_host_model_i.stop();
	endtask
	// Pointer write, repeated start, n bytes with the last one refused
	task automatic rd(input logic [7:0] a, input int n);
		logic ack;
		logic [8:0] r;
		q = {};
		ccr_host_model_i.start();
		put({SLAVE_ADDR, 1'b0}, ack);
		put(a, ack);
		ccr_host_model_i.start();
		put({SLAVE_ADDR, 1'b1}, ack);
		for (int i = 0; i < n; i++) begin
			ccr_host_model_i.xfer({8'hff, 1'(i == n - 1)}, r);
			q.push_back(r[8:1]);
		end
		ccr_host_model_i.stop();
	endtask
	// One-cycle pulse on {register reset, watchdog, detection}
	task automatic pulse(input logic [2:0] v);
		@(posedge clk_i);
		{regrst, wdog, det} <= v;
		@(posedge clk_i);
		{regrst, wdog, det} <= 3'h0;
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	task automatic rd_defaults();
		rd(8'h00, 3);
		check(q[0], 8'h17);
		check(q[1], 8'h1a);
		check(q[2], 8'h22);
	endtask

	////////////////////////////////////////
	task automatic t_defaults();
		rd_defaults();
		check(8'(chg_ok), 8'h01);
		check(8'(fet), 8'h01);
	endtask
	// All ones everywhere: reserved bits drop, kick self-clears, current clamps
	task automatic t_write_all();
		wr(8'h00, '{8'hff, 8'hff, 8'hff});
		check(8'(hiz), 8'h01);
		check(8'(fast_charge_current), 8'h32);
		check(8'(kick_cycles), 8'h01);
		rd(8'h00, 3);
		check(q[0], 8'h9f);
		check(q[1], 8'h9e);
		check(q[2], 8'h72);
	endtask
	task automatic t_watchdog();
		wr(8'h01, '{8'h8e});
		check(8'(chg_ok), 8'h00);
		pulse(3'b010);
		check(8'(pfm), 8'h01);
		check(8'(smin), 8'h07);
		rd(8'h00, 3);
		check(q[0], 8'h1f);
		check(q[1], 8'h9e);
		check(q[2], 8'h62);
	endtask
	task automatic t_reg_reset();
		pulse(3'b100);
		rd_defaults();
	endtask
	task automatic t_detect();
		@(posedge clk_i);
		psel <= 1'b1;
		pulse(3'b001);
		check(8'(ilim), 8'h04);
		check(8'(fet), 8'h00);
		wr(8'h00, '{8'h06});
		check(8'(ilim), 8'h06);
		check(8'(fet), 8'h01);
		@(posedge clk_i);
		psel <= 1'b0;
		pulse(3'b001);
		check(8'(ilim), 8'(LOW_CODE));
		wr(8'h02, '{8'h62});
		@(posedge clk_i);
		psel <= 1'b1;
		pulse(3'b001);
		check(8'(fet), 8'h01);
	endtask
	task automatic t_charge();
		@(posedge clk_i);
		ce_n <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		check(8'(chg_ok), 8'h00);
		@(posedge clk_i);
		ce_n <= 1'b0;
		wr(8'h02, '{8'h00});
		check(8'(chg_ok), 8'h00);
		wr(8'h02, '{8'h22});
		check(8'(chg_ok), 8'h01);
	endtask
	// Foreign address, undefined register, read past the map
	task automatic t_refuse();
		logic ack;
		ccr_host_model_i.start();
		put({7'h6b, 1'b0}, ack);
		check(8'(ack), 8'h00);
		ccr_host_model_i.stop();
		ccr_host_model_i.start();
		put({SLAVE_ADDR, 1'b0}, ack);
		put(8'h0c, ack);
		check(8'(ack), 8'h00);
		ccr_host_model_i.stop();
		rd(ADR_LAST_DEFINED, 2);
		check(q[1], 8'hff);
	endtask

	////////////////////////////////////////
	// Main sequence after ten reset cycles
	initial begin
		repeat (10) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		t_defaults();
		t_write_all();
		t_watchdog();
		t_reg_reset();
		t_detect();
		t_charge();
		t_refuse();
		stop_test();
	end
	// Hang guard: a run this long counts as a mismatch
	initial begin
		repeat (100000) @(posedge clk_i);
		fails++;
		stop_test();
	end
endmodule // tb_top
